// ---- src/scpu_pkg.sv ----
package scpu_pkg;
  localparam logic [15:0] RV_HI_DEF = 16'h6000;
  localparam logic [15:0] RV_HI_MIN = 16'h6000;
  localparam logic [15:0] RV_HI_MAX = 16'h8fff;
  localparam logic [15:0] RV_LO_DEF = 16'h0000;
  localparam logic [15:0] RV_LO_MAX = 16'hfffc;
  localparam int IRQ_W = 31;
  localparam int IO_AW = 31;
  // ------------------------------
  // address map
  // ------------------------------
  localparam logic [31:0] DBG_BASE = 32'h0000_0000;
  localparam logic [31:0] DBG_TOP = 32'h0000_1000;
  localparam logic [31:0] ERR_BASE = 32'h0000_3000;
  localparam logic [31:0] ERR_TOP = 32'h0000_4000;
  localparam logic [31:0] PIU_BASE = 32'h4000_0000;
  localparam logic [31:0] PIU_TOP = 32'h4400_0000;
  localparam logic [31:0] CLU_TOP = 32'h4401_0000;
  localparam logic [31:0] UNC_BASE = 32'h6000_0000;
  localparam logic [31:0] UNC_LAST = 32'h7fff_ffff;
  localparam logic [31:0] CAC_BASE = 32'h8000_0000;
  localparam logic [31:0] CAC_LAST = 32'h8fff_ffff;
  // ------------------------------
  // bus encodings
  // ------------------------------
  localparam logic [1:0] HT_IDLE = 2'h0;
  localparam logic [1:0] HT_NSEQ = 2'h2;
  localparam logic [2:0] HB_SINGLE = 3'h0;
  localparam logic [3:0] HP_CAC = 4'hf;
  localparam logic [3:0] HP_UNC = 4'h3;
  localparam logic [1:0] AX_OKAY = 2'h0;
  localparam logic [1:0] AX_SLVERR = 2'h2;
  // ------------------------------
  // registers
  // ------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ = 8'h08;
  localparam logic [7:0] REG_ECC = 8'h0c;
  localparam logic [7:0] REG_BOOT = 8'h10;
  localparam int CTRL_HALT = 0;
  localparam int CTRL_PRST = 1;
  localparam logic CTRL_HALT_RST = 1'b0;
  localparam logic [4:0] IR_CAPT = 5'h01;
  // ------------------------------
  // timing
  // ------------------------------
  localparam int CLK_NS = 50;
  localparam int PRST_NS = 1000;
  localparam logic [7:0] PRST_CYC = 8'((PRST_NS + CLK_NS - 1) / CLK_NS);
  typedef enum logic [1:0] {B_IDLE = 2'b00, B_ADDR = 2'b01, B_DATA = 2'b10} scpu_bus_t;
  typedef enum logic [1:0] {RG_LOC = 2'b00, RG_ERR = 2'b01, RG_UNC = 2'b10, RG_CAC = 2'b11} scpu_rgn_t;
  typedef enum logic [3:0] {
    T_EX2DR = 4'b0000, T_EX1DR = 4'b0001, T_SHDR = 4'b0010, T_PDR = 4'b0011,
    T_SELIR = 4'b0100, T_UDR = 4'b0101, T_CAPDR = 4'b0110, T_SELDR = 4'b0111,
    T_EX2IR = 4'b1000, T_EX1IR = 4'b1001, T_SHIR = 4'b1010, T_PIR = 4'b1011,
    T_RTI = 4'b1100, T_UIR = 4'b1101, T_CAPIR = 4'b1110, T_TLR = 4'b1111
  } scpu_tap_t;
endpackage

// ---- src/scpu_top.sv ----
// Functional notes
// R1: after reset fetch starts at reset vector; upper half 6000..8fff, default 6000.
// R2: lower vector half 0000..fffc, default zero, word aligned.
// R3: halt option off by default; when off halt ports are inert.
// R4: ecc option off by default; enables four cache error flag outputs.
// R5: all pins sampled and driven on the one system clock.
// R6: main reset is active low and synchronous.
// R7: peripheral reset output pulses when a debug session begins.
// R8: tms and tdi sampled on rising tck; tms picks next tap state.
// R9: optional tap reset input forces test-logic-reset.
// R10: tdo drive enable output qualifies an external tristate buffer.
// R11: 31 level interrupt inputs, held by sources until serviced.
// R12: high halt request stops instruction execution.
// R13: halted output asserts once execution has really stopped.
// R14: instruction cache corrected and double-error flags.
// R15: data cache corrected and double-error flags.
// R16: cached port is ahb master with select, 32-bit address and data.
// R17: uncached port is ahb master, 31-bit address, no select.
// R18: debug unit 0..1000, error device 3000..4000.
// R19: interrupt unit 40000000..44000000, core-local unit to 44010000.
// R20: 6000_0000..7fff_ffff uncached port, 8000_0000..8fff_ffff cached port.
// R21: cached port serves line refills, uncached port peripheral accesses.
// R22: uncached address carries low 31 bits of processor address.
//
// Our own choices: the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module scpu_top #(
  parameter logic [15:0] RV_HI = scpu_pkg::RV_HI_DEF,
  parameter logic [15:0] RV_LO = scpu_pkg::RV_LO_DEF,
  parameter bit HALT_OPT = 1'b0,
  parameter bit ECC_OPT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  output wire logic periphRstLow,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trstLow,
  output wire logic tdo,
  output wire logic tdoDriveEn,
  input wire logic [scpu_pkg::IRQ_W-1:0] irq,
  output wire logic [scpu_pkg::IRQ_W-1:0] irqPend,
  input wire logic haltReq,
  output wire logic cpuHalted,
  input wire logic eccISec,
  input wire logic eccIDed,
  input wire logic eccDSec,
  input wire logic eccDDed,
  output wire logic iCacheCorrected,
  output wire logic iCacheDoubleErr,
  output wire logic dCacheCorrected,
  output wire logic dCacheDoubleErr,
  input wire logic reqValid,
  output wire logic reqReady,
  input wire logic [31:0] reqAddr,
  input wire logic reqWrite,
  input wire logic [2:0] reqSize,
  input wire logic [31:0] reqWdata,
  output wire logic rspValid,
  output wire logic [31:0] rspData,
  output wire logic rspErr,
  output wire logic rspBoot,
  output wire logic memHlock,
  output wire logic [1:0] memHtrans,
  output wire logic memHsel,
  output wire logic memHwrite,
  output wire logic [31:0] memHaddr,
  output wire logic [2:0] memHsize,
  output wire logic [2:0] memHburst,
  output wire logic [3:0] memHprot,
  output wire logic [31:0] memHwdata,
  input wire logic memHready,
  input wire logic memHresp,
  input wire logic [31:0] memHrdata,
  output wire logic ioHlock,
  output wire logic [1:0] ioHtrans,
  output wire logic ioHwrite,
  output wire logic [scpu_pkg::IO_AW-1:0] ioHaddr,
  output wire logic [2:0] ioHsize,
  output wire logic [2:0] ioHburst,
  output wire logic [3:0] ioHprot,
  output wire logic [31:0] ioHwdata,
  input wire logic ioHready,
  input wire logic ioHresp,
  input wire logic [31:0] ioHrdata,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output wire logic s_axi_wready,
  output wire logic [1:0] s_axi_bresp,
  output wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output wire logic s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0] s_axi_rresp,
  output wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import scpu_pkg::*;

  typedef struct packed {
    scpu_bus_t bus;
    logic bootPend;
    logic unc;
    logic [31:0] wd;
    logic [31:0] boot;
    logic reqRdy;
    logic rspVal;
    logic [31:0] rspData;
    logic rspErr;
    logic rspBoot;
    logic curBoot;
    logic [1:0] mTrans;
    logic mSel;
    logic mWrite;
    logic [31:0] mAddr;
    logic [2:0] mSize;
    logic [31:0] mWdata;
    logic [1:0] uTrans;
    logic uWrite;
    logic [30:0] uAddr;
    logic [2:0] uSize;
    logic [31:0] uWdata;
    logic halted;
    logic haltSw;
    logic [30:0] irq;
    logic tckPrev;
    scpu_tap_t tap;
    logic [4:0] ir;
    logic byp;
    logic tdo;
    logic tdoEn;
    logic prstLow;
    logic [7:0] prstCnt;
    logic [3:0] ecc;
    logic [3:0] eccStk;
    logic awHave;
    logic wHave;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bVal;
    logic [1:0] bResp;
    logic arRdy;
    logic rVal;
    logic [31:0] rData;
    logic [1:0] rResp;
  } scpu_state_t;

  scpu_state_t s, n;

  // out-of-range upper vector half falls back to default; lower half is masked with fffc
  localparam logic [15:0] RVH = (RV_HI < RV_HI_MIN || RV_HI > RV_HI_MAX) ? RV_HI_DEF : RV_HI; // R1
  localparam logic [15:0] RVL = RV_LO & RV_LO_MAX; // R2

  function automatic scpu_rgn_t regionOf(input logic [31:0] a);
    if (a >= DBG_BASE && a < DBG_TOP) regionOf = RG_LOC; // R18
    else if (a >= ERR_BASE && a < ERR_TOP) regionOf = RG_ERR; // R18
    else if (a >= PIU_BASE && a < PIU_TOP) regionOf = RG_LOC; // R19
    else if (a >= PIU_TOP && a < CLU_TOP) regionOf = RG_LOC; // R19
    else if (a >= UNC_BASE && a <= UNC_LAST) regionOf = RG_UNC; // R20
    else if (a >= CAC_BASE && a <= CAC_LAST) regionOf = RG_CAC; // R20
    else regionOf = RG_ERR;
  endfunction

  function automatic scpu_tap_t tapNext(input scpu_tap_t t, input logic m);
    case (t)
      T_TLR: tapNext = m ? T_TLR : T_RTI;
      T_RTI: tapNext = m ? T_SELDR : T_RTI;
      T_SELDR: tapNext = m ? T_SELIR : T_CAPDR;
      T_CAPDR: tapNext = m ? T_EX1DR : T_SHDR;
      T_SHDR: tapNext = m ? T_EX1DR : T_SHDR;
      T_EX1DR: tapNext = m ? T_UDR : T_PDR;
      T_PDR: tapNext = m ? T_EX2DR : T_PDR;
      T_EX2DR: tapNext = m ? T_UDR : T_SHDR;
      T_UDR: tapNext = m ? T_SELDR : T_RTI;
      T_SELIR: tapNext = m ? T_TLR : T_CAPIR;
      T_CAPIR: tapNext = m ? T_EX1IR : T_SHIR;
      T_SHIR: tapNext = m ? T_EX1IR : T_SHIR;
      T_EX1IR: tapNext = m ? T_UIR : T_PIR;
      T_PIR: tapNext = m ? T_EX2IR : T_PIR;
      T_EX2IR: tapNext = m ? T_UIR : T_SHIR;
      default: tapNext = m ? T_SELDR : T_RTI;
    endcase
  endfunction

  logic haltEff;
  logic tckRise;
  logic tckFall;
  logic sessionGo;
  logic hrdy;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] sa;
  logic sw;
  logic [2:0] sz;
  logic go;
  logic [3:0] eccEvt;
  logic [3:0] eccClr;
  logic wrGo;
  scpu_rgn_t rg;

  always_comb
  begin
    n = s;
    haltEff = (HALT_OPT && haltReq) || s.haltSw; // R12
    tckRise = tck && !s.tckPrev; // R8
    tckFall = !tck && s.tckPrev;
    hrdy = s.unc ? ioHready : memHready;
    hresp = s.unc ? ioHresp : memHresp;
    hrdata = s.unc ? ioHrdata : memHrdata;
    eccClr = 4'h0;
    n.rspVal = 1'b0;
    n.rspBoot = 1'b0;
    // ------------------------------
    // request routing
    // ------------------------------
    go = 1'b0;
    sa = s.bootPend ? s.boot : reqAddr; // R1
    sw = s.bootPend ? 1'b0 : reqWrite;
    sz = s.bootPend ? 3'h2 : reqSize;
    rg = regionOf(sa);
    case (s.bus)
      B_IDLE:
      begin
        // halt is only granted between transfers, never mid-beat
        if (!haltEff && s.bootPend) go = 1'b1;
        else if (reqValid && s.reqRdy) go = 1'b1;
        if (go)
        begin
          n.curBoot = s.bootPend;
          n.bootPend = 1'b0;
          n.wd = reqWdata;
          if (rg == RG_UNC)
          begin
            n.unc = 1'b1; // R21
            n.uTrans = HT_NSEQ; // R17
            n.uAddr = sa[30:0]; // R22
            n.uWrite = sw;
            n.uSize = sz;
            n.bus = B_ADDR;
          end
          else if (rg == RG_CAC)
          begin
            n.unc = 1'b0; // R21
            n.mTrans = HT_NSEQ; // R16
            n.mAddr = sa;
            n.mWrite = sw;
            n.mSize = sz;
            n.bus = B_ADDR;
          end
          else
          begin
            // local units answer in place; the error device faults
            n.rspVal = 1'b1;
            n.rspData = 32'h0;
            n.rspErr = (rg == RG_ERR); // R18
            n.rspBoot = s.bootPend;
          end
        end
      end
      B_ADDR:
      begin
        if (hrdy)
        begin
          n.mTrans = HT_IDLE;
          n.uTrans = HT_IDLE;
          n.mWdata = s.unc ? s.mWdata : s.wd;
          n.uWdata = s.unc ? s.wd : s.uWdata;
          n.bus = B_DATA;
        end
      end
      default:
      begin
        if (hrdy)
        begin
          n.rspVal = 1'b1;
          n.rspData = hrdata;
          n.rspErr = hresp;
          n.rspBoot = s.curBoot;
          n.bus = B_IDLE;
        end
      end
    endcase
    n.reqRdy = (n.bus == B_IDLE) && !n.bootPend && !haltEff; // R12
    n.halted = haltEff && (n.bus == B_IDLE); // R13
    n.mSel = (n.mTrans != HT_IDLE); // R16
    n.irq = irq; // R11
    // ------------------------------
    // debug port
    // ------------------------------
    n.tckPrev = tck;
    sessionGo = 1'b0;
    if (!trstLow)
    begin
      n.tap = T_TLR; // R9
      n.ir = IR_CAPT;
    end
    else if (tckRise)
    begin
      n.tap = tapNext(s.tap, tms); // R8
      sessionGo = (s.tap == T_TLR) && !tms;
      if (s.tap == T_CAPIR) n.ir = IR_CAPT;
      else if (s.tap == T_SHIR) n.ir = {tdi, s.ir[4:1]}; // R8
      if (s.tap == T_CAPDR) n.byp = 1'b0;
      else if (s.tap == T_SHDR) n.byp = tdi; // R8
    end
    if (tckFall)
    begin
      n.tdo = (s.tap == T_SHIR) ? s.ir[0] : s.byp;
      n.tdoEn = (s.tap == T_SHIR) || (s.tap == T_SHDR); // R10
    end
    // ------------------------------
    // register slave
    // ------------------------------
    if (s_axi_awvalid && !s.awHave && !s.bVal)
    begin
      n.awHave = 1'b1;
      n.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.wHave && !s.bVal)
    begin
      n.wHave = 1'b1;
      n.wData = s_axi_wdata;
      n.wStrb = s_axi_wstrb;
    end
    wrGo = s.awHave && s.wHave;
    if (wrGo)
    begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bVal = 1'b1;
      n.bResp = AX_OKAY;
      if (s.awAddr == REG_CTRL)
      begin
        if (s.wStrb[0])
        begin
          n.haltSw = s.wData[CTRL_HALT]; // R12
          sessionGo = sessionGo || s.wData[CTRL_PRST];
        end
      end
      else if (s.awAddr == REG_ECC)
      begin
        if (s.wStrb[0]) eccClr = s.wData[3:0];
      end
      else if (s.awAddr == REG_STAT || s.awAddr == REG_IRQ || s.awAddr == REG_BOOT)
      begin
        n.bResp = AX_OKAY;
      end
      else
      begin
        n.bResp = AX_SLVERR;
      end
    end
    else if (s.bVal && s_axi_bready)
    begin
      n.bVal = 1'b0;
    end
    n.arRdy = 1'b0;
    if (s.rVal)
    begin
      if (s_axi_rready) n.rVal = 1'b0;
    end
    else if (s_axi_arvalid && s.arRdy)
    begin
      n.rVal = 1'b1;
      n.rResp = AX_OKAY;
      if (s_axi_araddr == REG_CTRL) n.rData = {31'h0, s.haltSw};
      else if (s_axi_araddr == REG_STAT) n.rData = {29'h0, s.tap == T_TLR, s.halted, s.bus != B_IDLE};
      else if (s_axi_araddr == REG_IRQ) n.rData = {1'b0, s.irq};
      else if (s_axi_araddr == REG_ECC) n.rData = {28'h0, s.eccStk};
      else if (s_axi_araddr == REG_BOOT) n.rData = s.boot;
      else
      begin
        n.rData = 32'h0;
        n.rResp = AX_SLVERR;
      end
    end
    else
    begin
      n.arRdy = !s_axi_arvalid || !s.arRdy;
    end
    // ------------------------------
    // peripheral reset pulse
    // ------------------------------
    if (sessionGo)
    begin
      n.prstLow = 1'b0; // R7
      n.prstCnt = PRST_CYC;
    end
    else if (s.prstCnt > 8'h1)
    begin
      n.prstCnt = s.prstCnt - 8'h1;
    end
    else
    begin
      n.prstCnt = 8'h0;
      n.prstLow = 1'b1;
    end
    // ------------------------------
    // cache error flags
    // ------------------------------
    eccEvt = ECC_OPT ? {eccDDed, eccDSec, eccIDed, eccISec} : 4'h0; // R4
    n.ecc = eccEvt; // R14 R15
    // a new event beats a clear in the same cycle
    n.eccStk = (s.eccStk & ~eccClr) | eccEvt;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst) // R6
    begin
      s <= '0;
      s.bootPend <= 1'b1;
      s.boot <= {RVH, RVL}; // R1 R2
      s.haltSw <= CTRL_HALT_RST;
      s.tap <= T_TLR;
      s.ir <= IR_CAPT;
      s.prstLow <= 1'b1;
      s.arRdy <= 1'b1;
    end
    else
    begin
      s <= n; // R5
    end
  end

  assign periphRstLow = s.prstLow;
  assign tdo = s.tdo;
  assign tdoDriveEn = s.tdoEn;
  assign irqPend = s.irq;
  assign cpuHalted = HALT_OPT && s.halted; // R3
  assign iCacheCorrected = s.ecc[0];
  assign iCacheDoubleErr = s.ecc[1];
  assign dCacheCorrected = s.ecc[2];
  assign dCacheDoubleErr = s.ecc[3];
  assign reqReady = s.reqRdy;
  assign rspValid = s.rspVal;
  assign rspData = s.rspData;
  assign rspErr = s.rspErr;
  assign rspBoot = s.rspBoot;
  assign memHlock = 1'b0;
  assign memHtrans = s.mTrans;
  assign memHsel = s.mSel;
  assign memHwrite = s.mWrite;
  assign memHaddr = s.mAddr;
  assign memHsize = s.mSize;
  assign memHburst = HB_SINGLE;
  assign memHprot = HP_CAC;
  assign memHwdata = s.mWdata;
  assign ioHlock = 1'b0;
  assign ioHtrans = s.uTrans;
  assign ioHwrite = s.uWrite;
  assign ioHaddr = s.uAddr;
  assign ioHsize = s.uSize;
  assign ioHburst = HB_SINGLE;
  assign ioHprot = HP_UNC;
  assign ioHwdata = s.uWdata;
  assign s_axi_awready = !s.awHave && !s.bVal;
  assign s_axi_wready = !s.wHave && !s.bVal;
  assign s_axi_bvalid = s.bVal;
  assign s_axi_bresp = s.bResp;
  assign s_axi_arready = s.arRdy;
  assign s_axi_rvalid = s.rVal;
  assign s_axi_rdata = s.rData;
  assign s_axi_rresp = s.rResp;

  // ------------------------------
  // checks
  // ------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence bootIssue;
    s.bus == B_ADDR && s.curBoot;
  endsequence

  a_boot_vector: assert property ($rose(nrst) |=> bootIssue ##0 // R1
    ((s.unc && {1'b0, s.uAddr} == {1'b0, RVL[15:0] == s.boot[15:0] ? s.boot[30:0] : 31'h0}) ||
     (!s.unc && s.mAddr == s.boot)))
    else $error("boot fetch not at reset vector");
  a_vector_align: assert property (s.boot[1:0] == 2'h0 && s.boot[31:16] >= RV_HI_MIN) // R2
    else $error("reset vector out of range");
  a_halt_ack: assert property (haltEff && s.bus == B_IDLE && !(reqValid && s.reqRdy) |=> s.halted && !s.reqRdy) // R13
    else $error("halt not acknowledged");
  a_halt_quiet: assert property (s.halted |-> s.mTrans == HT_IDLE && s.uTrans == HT_IDLE) // R12
    else $error("transfer while halted");
  a_tap_trst: assert property (!trstLow |=> s.tap == T_TLR) // R9
    else $error("tap not reset");
  a_tap_hold: assert property (trstLow && !tckRise |=> $stable(s.tap)) // R8
    else $error("tap moved without tck edge");
  a_prst_pulse: assert property ($fell(s.prstLow) |-> !s.prstLow [*8]) // R7
    else $error("peripheral reset too short");
  a_irq_level: assert property (s.irq == $past(irq)) // R11
    else $error("interrupt not sampled");
  a_ecc_flag: assert property (ECC_OPT && eccDDed |=> dCacheDoubleErr && s.eccStk[3]) // R15
    else $error("data cache flag missed");
  a_io_addr: assert property (s.uTrans == HT_NSEQ |-> {1'b0, s.uAddr} >= UNC_BASE[31:0] - 32'h0) // R22
    else $error("uncached address low");
  a_mem_sel: assert property (s.mTrans == HT_NSEQ |-> memHsel && s.mAddr >= CAC_BASE) // R16
    else $error("cached select missing");
  a_err_region: assert property (reqValid && s.reqRdy && !s.bootPend && regionOf(reqAddr) == RG_ERR
    |=> s.rspVal && s.rspErr) // R18
    else $error("error device did not fault");
endmodule
`default_nettype wire

// ---- bench/scpu_ahb_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module scpu_ahb_model #(
  parameter int WAITS = 0
) (
  input wire logic clk,
  input wire logic rstLow,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  output logic hready,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [31:0] lastAddr,
  output logic [31:0] lastWdata
);
  import scpu_pkg::*;
  logic dph;
  logic wr;
  logic [31:0] aq;
  logic [31:0] dq;
  int cnt;
  // outside a read data phase the read bus shows the inverse of what it showed at the last unstalled edge
  assign hready = !dph || cnt == 0;
  assign hresp = 1'b0;
  assign hrdata = (dph && !wr) ? ({aq[15:0], aq[31:16]} ^ 32'ha5a5_a5a5) : ~dq;
  always @(posedge clk)
  begin
    if (!rstLow)
    begin
      dph <= 1'b0;
      cnt <= 0;
      dq <= 32'h0;
    end
    else if (dph && cnt != 0)
      cnt <= cnt - 1;
    else
    begin
      if (dph && wr)
        lastWdata <= hwdata;
      dq <= hrdata;
      dph <= htrans == HT_NSEQ;
      if (htrans == HT_NSEQ)
      begin
        aq <= haddr;
        wr <= hwrite;
        lastAddr <= haddr;
        cnt <= WAITS;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import scpu_pkg::*;
  logic ref_clk = 1'b0, nrst, periphRstLow, tck, tms, tdi, trstLow, tdo, tdoDriveEn;
  logic [30:0] irq, irqPend, ioHaddr;
  logic haltReq, cpuHalted, eccISec, eccIDed, eccDSec, eccDDed;
  logic iCacheCorrected, iCacheDoubleErr, dCacheCorrected, dCacheDoubleErr;
  logic reqValid, reqReady, reqWrite, rspValid, rspErr, rspBoot;
  logic [31:0] reqAddr, reqWdata, rspData, memHaddr, memHwdata, memHrdata, ioHwdata, ioHrdata;
  logic [31:0] s_axi_wdata, s_axi_rdata, memA, memW, ioA, ioW;
  logic [2:0] reqSize, memHsize, memHburst, ioHsize, ioHburst;
  logic memHlock, memHsel, memHwrite, memHready, memHresp, ioHlock, ioHwrite, ioHready, ioHresp;
  logic [1:0] memHtrans, ioHtrans, s_axi_bresp, s_axi_rresp;
  logic [3:0] memHprot, ioHprot, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int fails = 0;
  int checks = 0;
  logic [31:0] mapA [12] = '{32'h0000_0ffc, 32'h0000_3000, 32'h0000_3ffc, 32'h4000_0000, 32'h4400_fffc,
    32'h4401_0000, 32'h6000_0010, 32'h7fff_fffc, 32'h8000_0020, 32'h8fff_fffc, 32'h9000_0000, 32'h5000_0000};
  logic [1:0] mapK [12] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1, 2'h1};
  scpu_top #(.RV_HI(16'h8000), .RV_LO(16'h0104), .HALT_OPT(1'b1), .ECC_OPT(1'b1)) dut_u (.*);
  // wait states on the cached side, prompt answers on the uncached side
  scpu_ahb_model #(.WAITS(2)) mem_u (.clk(ref_clk), .rstLow(nrst), .htrans(memHtrans), .haddr(memHaddr),
    .hwrite(memHwrite), .hwdata(memHwdata), .hready(memHready), .hresp(memHresp), .hrdata(memHrdata),
    .lastAddr(memA), .lastWdata(memW));
  scpu_ahb_model io_u (.clk(ref_clk), .rstLow(nrst), .htrans(ioHtrans), .haddr({1'b0, ioHaddr}),
    .hwrite(ioHwrite), .hwdata(ioHwdata), .hready(ioHready), .hresp(ioHresp), .hrdata(ioHrdata),
    .lastAddr(ioA), .lastWdata(ioW));
  always #25 ref_clk = ~ref_clk;
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report;
    $display("TB: checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    // bready stays high between writes
    chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic axiRd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    // rready stays high between reads
    chk("rvalid", 32'h1, {31'h0, s_axi_rvalid});
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    if (er == AX_OKAY)
      chk("rdata", d, s_axi_rdata);
  endtask
  task automatic core(input logic [31:0] a, input logic w, input logic [31:0] wd, input logic ee, input logic [31:0] ed);
    int n = 0;
    reqValid <= 1'b1;
    reqAddr <= a;
    reqWrite <= w;
    reqWdata <= wd;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (!reqReady && n < 300);
    reqValid <= 1'b0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (!rspValid && n < 300);
    chk("rspValid", 32'h1, {31'h0, rspValid});
    chk("rspErr", {31'h0, ee}, {31'h0, rspErr});
    if (!ee && !w)
      chk("rspData", ed, rspData);
  endtask
  task automatic tckStep(input logic v);
    tms <= v;
    repeat (4) @(posedge ref_clk);
    tck <= 1'b1;
    repeat (4) @(posedge ref_clk);
    tck <= 1'b0;
    // let the falling edge reach tdo and its enable
    repeat (2) @(posedge ref_clk);
  endtask
  // ------------------------------
  // tests
  // ------------------------------
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    final_report;
  end
  initial
  begin
    logic [31:0] aq;
    int n;
    {nrst, tck, tms, tdi, trstLow, haltReq, reqValid, reqWrite} = 8'h18;
    {eccISec, eccIDed, eccDSec, eccDDed, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 7'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {irq, reqAddr, reqWdata, s_axi_wdata, s_axi_awaddr, s_axi_araddr} = '0;
    reqSize = 3'h2;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge ref_clk);
    chk("rstHtrans", {30'h0, HT_IDLE}, {30'h0, memHtrans});
    chk("rstPrst", 32'h1, {31'h0, periphRstLow});
    nrst <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (!rspBoot && n < 300);
    chk("bootSeen", 32'h1, {31'h0, rspBoot});
    chk("bootAddr", 32'h8000_0104, memA);
    axiRd(REG_BOOT, 32'h8000_0104, AX_OKAY);
    axiRd(8'h40, 32'h0, AX_SLVERR);
    for (int i = 0; i < 12; i++)
    begin
      aq = (mapK[i] == 2'h2) ? {1'b0, mapA[i][30:0]} : mapA[i];
      core(mapA[i], 1'b0, 32'h0, mapK[i] == 2'h1, mapK[i] == 2'h0 ? 32'h0 : {aq[15:0], aq[31:16]} ^ 32'ha5a5_a5a5);
      if (mapK[i] == 2'h2)
        chk("ioAddr", aq, ioA);
      if (mapK[i] == 2'h3)
        chk("memAddr", aq, memA);
    end
    core(32'h6000_0040, 1'b1, 32'hcafe_0001, 1'b0, 32'h0);
    chk("ioWdata", 32'hcafe_0001, ioW);
    chk("ioAttr", {21'h0, 1'b0, HB_SINGLE, HP_UNC, 3'h2}, {21'h0, ioHlock, ioHburst, ioHprot, ioHsize});
    core(32'h8000_0080, 1'b1, 32'hbeef_0002, 1'b0, 32'h0);
    chk("memWdata", 32'hbeef_0002, memW);
    chk("memAttr", {21'h0, 1'b0, HB_SINGLE, HP_CAC, 3'h2}, {21'h0, memHlock, memHburst, memHprot, memHsize});
    for (int i = 0; i < 4; i++)
    begin
      {eccDDed, eccDSec, eccIDed, eccISec} <= 4'(1 << i);
      @(posedge ref_clk);
      {eccDDed, eccDSec, eccIDed, eccISec} <= 4'h0;
      @(posedge ref_clk);
      chk("eccFlag", 32'(1 << i), {28'h0, dCacheDoubleErr, dCacheCorrected, iCacheDoubleErr, iCacheCorrected});
    end
    axiRd(REG_ECC, 32'hf, AX_OKAY);
    axiWr(REG_ECC, 32'hf, AX_OKAY);
    axiRd(REG_ECC, 32'h0, AX_OKAY);
    irq <= 31'h4000_0001;
    repeat (2) @(posedge ref_clk);
    chk("irqPend", 32'h4000_0001, {1'b0, irqPend});
    axiRd(REG_IRQ, 32'h4000_0001, AX_OKAY);
    axiWr(REG_CTRL, 32'h3, AX_OKAY);
    // the first low cycle already stands when the write returns
    n = periphRstLow ? 0 : 1;
    repeat (60)
    begin
      @(posedge ref_clk);
      n += periphRstLow ? 0 : 1;
    end
    chk("prstCycles", 32'(PRST_CYC), 32'(n));
    axiRd(REG_CTRL, 32'h1, AX_OKAY);
    chk("swHalt", 32'h1, {31'h0, cpuHalted});
    axiWr(REG_CTRL, 32'h0, AX_OKAY);
    haltReq <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (!cpuHalted && n < 100);
    chk("halted", 32'h1, {31'h0, cpuHalted});
    chk("haltReady", 32'h0, {31'h0, reqReady});
    haltReq <= 1'b0;
    repeat (20) @(posedge ref_clk);
    chk("unhalted", 32'h0, {31'h0, cpuHalted});
    trstLow <= 1'b0;
    repeat (3) @(posedge ref_clk);
    trstLow <= 1'b1;
    axiRd(REG_STAT, 32'h4, AX_OKAY);
    tckStep(1'b0);
    chk("sessionPrst", 32'h0, {31'h0, periphRstLow});
    tckStep(1'b1);
    tckStep(1'b1);
    tckStep(1'b0);
    tckStep(1'b0);
    chk("shiftDrive", 32'h1, {31'h0, tdoDriveEn});
    chk("tdoCapture", 32'h1, {31'h0, tdo});
    tckStep(1'b1);
    chk("exitDrive", 32'h0, {31'h0, tdoDriveEn});
    final_report;
  end
endmodule
`default_nettype wire
